/* File: aasp_serial_port.sv */
/*
  Audio serial output port: I2S and TDM (1 to 8 slots) streaming of x, y, z and temperature
  samples, and two-edge PDM of x, y and z only, with an 8 word sample FIFO in front.
  Assumes bclk_in and frame_sync_in are already synchronous to mclk, and that
  mclk is many times faster than the bit clock so both its edges are seen.
*/
`timescale 1ns/1ns
`default_nettype none

module aasp_fifo #(
  parameter int unsigned W = 64,
  parameter int unsigned DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } aasp_fifo_st_t;
  aasp_fifo_st_t q, d;
  logic push, pop;

  // Pointer arithmetic wraps, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
    $error("aasp_fifo: DEPTH must be a power of two of at least 2");
  end

  // Handshakes are combinational from the count; data comes from storage
  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module aasp_serial_port import aasp_pkg::*; #(
  parameter int unsigned HP_GAP = RATE_HP_CYCLES,
  parameter int unsigned RBW_GAP = RATE_RBW_CYCLES,
  parameter int unsigned LP_GAP = RATE_LP_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic bclk_in,
  input wire logic frame_sync_in,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [15:0] sample_x,
  input wire logic [15:0] sample_y,
  input wire logic [15:0] sample_z,
  input wire logic [15:0] sample_temp,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic serial_out_zero,
  output logic serial_out_zero_oe,
  output logic serial_out_one,
  output logic serial_out_one_oe,
  output logic system_clock_tick
);
  localparam int unsigned SW = SAMPLE_W * CHANNELS;
  typedef struct packed {
    logic [7:0] clk_ctrl;
    logic [7:0] chan_en;
    logic [7:0] buf_cfg0;
    logic [7:0] serial_port_config_two;
    logic [7:0] pdm_slot;
    logic [7:0] density_polarity_invert;
    logic [7:0] rdata;
    logic bclk_prev;
    logic fs_prev;
    logic [3:0] div_cnt;
    logic sys_tick;
    logic [7:0] gen_cnt;
    logic gen_bclk;
    logic gen_fs;
    logic [5:0] gen_bit;
    aasp_frame_t fst;
    logic lr;
    logic [4:0] bit_cnt;
    logic [2:0] slot_cnt;
    logic [SW-1:0] sample;
    logic [15:0] rate_cnt;
    logic out0;
    logic out1;
    logic [2:0][15:0] acc;
    logic [2:0] pdm_bit;
    logic pdm0_oe;
    logic pdm1_oe;
  } aasp_state_t;
  aasp_state_t q, d;

  if (HP_GAP < 2 || RBW_GAP < 2 || LP_GAP < 2 ||
      HP_GAP > 65536 || RBW_GAP > 65536 || LP_GAP > 65536) begin : g_bad
    $error("aasp_serial_port: sample gaps must lie between 2 and 65536 cycles");
  end
  if (CTRL_BITS_PER_FRAME != 64 || CTRL_HALF_CYCLES > 256) begin : g_bad_ctrl
    $error("aasp_serial_port: generated frame must be 64 bit clocks");
  end

  // Last bit index of a slot for each width code
  function automatic logic [4:0] word_last(input logic [1:0] code);
    if (code == WW_16) begin
      return 5'h0F;
    end else if (code == WW_24) begin
      return 5'h17;
    end
    return 5'h1F;
  endfunction

  // n-th enabled channel in x, y, z, temperature order, {valid, index}
  function automatic logic [2:0] nth_chan(input logic [3:0] en, input logic [2:0] n);
    logic [2:0] seen;
    logic [2:0] res;
    seen = 3'h0;
    res = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        if (seen == n) begin
          res = {1'b1, 2'(i)};
        end
        seen = seen + 3'h1;
      end
    end
    return res;
  endfunction

  // Channel carried by a pin in the current slot, {valid, index}
  function automatic logic [2:0] slot_chan(input logic pin, input logic tdm_w,
      input logic both, input logic lr, input logic [2:0] slot, input logic [3:0] en);
    logic [1:0] idx;
    idx = {pin, lr};
    if (tdm_w && !both) begin
      return nth_chan(en, slot);
    end else if (tdm_w) begin
      idx = {pin, slot[0]};
    end
    return {en[idx], idx};
  endfunction

  // Serial bit of a slot: MSB first, zero beyond the sample or if empty
  function automatic logic slot_bit(input logic [SW-1:0] smp, input logic [2:0] ch,
      input logic [4:0] bc);
    logic [15:0] w;
    w = smp[{ch[1:0], 4'h0} +: 16];
    if (!ch[2] || bc > 5'h0F) begin
      return 1'b0;
    end
    return w[4'hF - bc[3:0]];
  endfunction

  // PDM drive of one slot, {enable, value}
  function automatic logic [1:0] pdm_pin(input logic [1:0] sel, input logic [2:0] bits,
      input logic inv);
    if (sel == SLOT_NONE) begin
      return 2'b00;
    end
    return {1'b1, bits[sel] ^ inv};
  endfunction

  logic ctrl_mode, bclk, fs, rise, fall, tdm, pdm, start, pop, both_pins;
  logic f_valid, f_ready;
  logic [SW-1:0] f_data;
  logic [3:0] slots;
  logic [4:0] last_bit;
  logic [2:0] ch0, ch1;
  logic [15:0] gap_m1;
  aasp_pwr_t pwr;

  // Bit clock and frame sync source: pin or generated
  assign ctrl_mode = q.clk_ctrl[CTRL_MODE_BIT];
  assign bclk = ctrl_mode ? q.gen_bclk : bclk_in;
  assign fs = ctrl_mode ? q.gen_fs : frame_sync_in;
  assign rise = bclk && !q.bclk_prev;
  assign fall = !bclk && q.bclk_prev;
  assign tdm = q.buf_cfg0[SYNC_STYLE_BIT];
  assign pdm = q.density_polarity_invert[PDM_EN_BIT];
  assign slots = {1'b0, q.serial_port_config_two[SLOTS_LSB +: 3]} + 4'h1;
  assign last_bit = word_last(q.serial_port_config_two[WIDTH_LSB +: 2]);
  assign both_pins = !tdm || slots == 4'h2;
  assign pwr = aasp_pwr_t'(q.serial_port_config_two[PWR_LSB +: 2]);

  // TDM: pulse high at a rising edge I2S: any level change
  assign start = rise && !pdm && (tdm ? fs : (fs != q.fs_prev));
  // New sample only while the rate gap has run out
  assign pop = f_valid && q.rate_cnt == 16'h0000 &&
               (pdm ? rise : (start && (tdm || !fs)));
  assign f_ready = pop;

  // Gap per power mode; the unused code is treated as the slowest
  always_comb begin
    case (pwr)
      AASP_HP: gap_m1 = 16'(HP_GAP - 1);
      AASP_RBW: gap_m1 = 16'(RBW_GAP - 1);
      default: gap_m1 = 16'(LP_GAP - 1);
    endcase
  end

  // Lane mapping for the two serial outputs
  assign ch0 = slot_chan(1'b0, tdm, both_pins, q.lr, q.slot_cnt, q.chan_en[3:0]);
  assign ch1 = slot_chan(1'b1, tdm, both_pins, q.lr, q.slot_cnt, q.chan_en[3:0]);

  aasp_fifo #(.W(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_temp, sample_z, sample_y, sample_x}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Next state of the whole port
  always_comb begin
    logic [16:0] sum;
    logic [1:0] drv0, drv1;
    sum = 17'h0;
    drv0 = 2'b00;
    drv1 = 2'b00;
    d = q;
    d.sys_tick = 1'b0;
    d.bclk_prev = bclk;
    // Register writes
    if (reg_wr_en) begin
      if (reg_addr == ADDR_CLK_CTRL) begin
        d.clk_ctrl = reg_wdata;
      end else if (reg_addr == ADDR_CHAN_EN) begin
        d.chan_en = reg_wdata;
      end else if (reg_addr == ADDR_BUF_CFG0) begin
        // A new format drops the running frame; a stale slot count could overrun
        d.buf_cfg0 = reg_wdata;
        d.fst = AASP_IDLE;
      end else if (reg_addr == ADDR_SERIAL_PORT_CONFIG_TWO) begin
        d.serial_port_config_two = reg_wdata;
        d.fst = AASP_IDLE;
      end else if (reg_addr == ADDR_PDM_SLOT) begin
        d.pdm_slot = reg_wdata;
      end else if (reg_addr == ADDR_DENSITY_POLARITY_INVERT) begin
        d.density_polarity_invert = reg_wdata;
      end
    end
    // Registered read data; unmapped offsets read zero
    if (reg_addr == ADDR_CLK_CTRL) begin
      d.rdata = q.clk_ctrl;
    end else if (reg_addr == ADDR_CHAN_EN) begin
      d.rdata = q.chan_en;
    end else if (reg_addr == ADDR_BUF_CFG0) begin
      d.rdata = q.buf_cfg0;
    end else if (reg_addr == ADDR_SERIAL_PORT_CONFIG_TWO) begin
      d.rdata = q.serial_port_config_two;
    end else if (reg_addr == ADDR_PDM_SLOT) begin
      d.rdata = q.pdm_slot;
    end else if (reg_addr == ADDR_DENSITY_POLARITY_INVERT) begin
      d.rdata = q.density_polarity_invert;
    end else if (reg_addr == ADDR_STATUS) begin
      d.rdata = {5'h00, f_valid, q.lr, q.fst == AASP_SHIFT};
    end else begin
      d.rdata = 8'h00;
    end
    // System clock divider: field value N divides by N plus one
    if (rise) begin
      if (q.div_cnt >= q.clk_ctrl[DIV_LSB +: 4]) begin
        d.div_cnt = 4'h0;
        d.sys_tick = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 4'h1;
      end
    end
    // Generated clock; sync moves on the falling edge, 64 bits a frame
    if (!ctrl_mode) begin
      d.gen_cnt = 8'h00;
      d.gen_bclk = 1'b0;
    end else if (q.gen_cnt == 8'(CTRL_HALF_CYCLES - 1)) begin
      d.gen_cnt = 8'h00;
      d.gen_bclk = !q.gen_bclk;
      if (q.gen_bclk) begin
        d.gen_bit = q.gen_bit + 6'h01;
        d.gen_fs = tdm ? (d.gen_bit == 6'h00) : (d.gen_bit >= 6'(CTRL_BITS_PER_FRAME / 2));
      end
    end else begin
      d.gen_cnt = q.gen_cnt + 8'h01;
    end
    // Sample rate gap
    if (pop) begin
      d.sample = f_data;
      d.rate_cnt = gap_m1;
    end else if (q.rate_cnt != 16'h0000) begin
      d.rate_cnt = q.rate_cnt - 16'h0001;
    end
    if (rise) begin
      d.fs_prev = fs;
    end
    if (pdm) begin
      d.fst = AASP_IDLE;
      // First order modulator per axis: carry density is linear in the
      // offset binary sample, so mid code gives 50 percent
      if (rise) begin
        for (int i = 0; i < 3; i++) begin
          sum = {1'b0, q.acc[i]} + {1'b0, ~q.sample[i*16+15], q.sample[i*16 +: 15]};
          d.acc[i] = sum[15:0];
          d.pdm_bit[i] = sum[16];
        end
        // Slot B on the rising edge
        drv0 = pdm_pin(q.pdm_slot[3:2], d.pdm_bit, q.density_polarity_invert[POL_BIT]);
        drv1 = pdm_pin(q.pdm_slot[7:6], d.pdm_bit, q.density_polarity_invert[POL_BIT]);
      end else if (fall) begin
        // Slot A on the falling edge
        drv0 = pdm_pin(q.pdm_slot[1:0], q.pdm_bit, q.density_polarity_invert[POL_BIT]);
        drv1 = pdm_pin(q.pdm_slot[5:4], q.pdm_bit, q.density_polarity_invert[POL_BIT]);
      end
      if (rise || fall) begin
        // Unassigned slot releases the line for that slot
        d.pdm0_oe = drv0[1];
        d.out0 = drv0[0];
        d.pdm1_oe = drv1[1];
        d.out1 = drv1[0];
      end
    end else if (start) begin
      // Frame or half frame begins; I2S level picks the side
      d.fst = AASP_SHIFT;
      d.lr = tdm ? 1'b0 : fs;
      d.bit_cnt = 5'h00;
      d.slot_cnt = 3'h0;
    end else if (fall && q.fst == AASP_SHIFT) begin
      // Shift on falling edges, MSB first and zero padded
      d.out0 = slot_bit(q.sample, ch0, q.bit_cnt);
      d.out1 = slot_bit(q.sample, ch1, q.bit_cnt);
      if (q.bit_cnt == last_bit) begin
        d.bit_cnt = 5'h00;
        // Slots run until the count or the next pulse
        if (!tdm || {1'b0, q.slot_cnt} == slots - 4'h1) begin
          d.fst = AASP_IDLE;
        end else begin
          d.slot_cnt = q.slot_cnt + 3'h1;
        end
      end else begin
        d.bit_cnt = q.bit_cnt + 5'h01;
      end
    end else if (fall) begin
      d.out0 = 1'b0;
      d.out1 = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.pdm_slot <= RST_PDM_SLOT;
    end else begin
      q <= d;
    end
  end

  // Pin drive; the frame sync pin becomes a data line in PDM
  assign reg_rdata = q.rdata;
  assign bit_clock_out = q.gen_bclk;
  assign bit_clock_oe = ctrl_mode;
  assign frame_sync_out = pdm ? q.out1 : q.gen_fs;
  assign frame_sync_oe = pdm ? q.pdm1_oe : ctrl_mode;
  assign serial_out_zero = q.out0;
  assign serial_out_zero_oe = pdm ? q.pdm0_oe : (both_pins || !q.serial_port_config_two[PIN_SEL_BIT]);
  assign serial_out_one = q.out1;
  assign serial_out_one_oe = !pdm && (both_pins || q.serial_port_config_two[PIN_SEL_BIT]);
  assign system_clock_tick = q.sys_tick;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_tick_edge;
    system_clock_tick |-> $past(rise);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("tick without bit clock edge");

  property p_div_count;
    (rise && q.div_cnt == 4'h3 && q.clk_ctrl[7:4] == 4'h3) |=> system_clock_tick;
  endproperty
  a_div_count: assert property (p_div_count) else $error("divide by four missed");

  property p_tdm_start;
    (start && tdm && !pdm) |=> (q.fst == AASP_SHIFT && q.bit_cnt == 5'h00 && q.slot_cnt == 3'h0);
  endproperty
  a_tdm_start: assert property (p_tdm_start) else $error("tdm frame did not start");

  property p_slot_bound;
    q.fst == AASP_SHIFT |-> ({1'b0, q.slot_cnt} < slots);
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("slot count overrun");

  property p_pin_sel;
    (!pdm && tdm && slots > 4'h2 && q.serial_port_config_two[PIN_SEL_BIT]) |->
      (!serial_out_zero_oe && serial_out_one_oe);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("wrong tdm pin driven");

  property p_pdm_hiz;
    (pdm && rise && q.pdm_slot[3:2] == SLOT_NONE && !reg_wr_en) |=> !serial_out_zero_oe;
  endproperty
  a_pdm_hiz: assert property (p_pdm_hiz) else $error("empty pdm slot driven");

  property p_pdm_map;
    (pdm && rise && q.pdm_slot == 8'h31 && !reg_wr_en) |=>
      (serial_out_zero_oe && serial_out_zero == (q.pdm_bit[0] ^ q.density_polarity_invert[POL_BIT]));
  endproperty
  a_pdm_map: assert property (p_pdm_map) else $error("x not in slot B");

  property p_pad;
    (q.fst == AASP_SHIFT && fall && !start && !pdm && q.bit_cnt > 5'h0F) |=>
      (!serial_out_zero && !serial_out_one);
  endproperty
  a_pad: assert property (p_pad) else $error("padding bit not zero");

  property p_rate;
    (pop && pwr == AASP_HP) |=> (q.rate_cnt == 16'(HP_GAP - 1)) ##1 !pop;
  endproperty
  a_rate: assert property (p_rate) else $error("sample rate gap not loaded");

  property p_sub_pins;
    (!ctrl_mode && !pdm) |-> (!frame_sync_oe && !bit_clock_oe);
  endproperty
  a_sub_pins: assert property (p_sub_pins) else $error("drove an input pin");

  c_tdm_frame: cover property (start && tdm ##[1:1000] (q.fst == AASP_SHIFT && q.slot_cnt == 3'h3));
  c_i2s_pop: cover property (pop && !tdm && !pdm);
  c_pdm_run: cover property (pdm && rise && serial_out_zero_oe ##[1:300] fall);
endmodule
`default_nettype wire

/* File: aasp_pkg.sv */
/*
  Constants shared by the accelerometer audio serial port: register offsets,
  field positions, reset values, timing counts and mode encodings.
  Assumes a 100 MHz core clock and the register write port of aasp_serial_port.
*/
`default_nettype none
package aasp_pkg;
  // Core clock and nominal rates
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SYS_CLK_HZ = 512_000;
  localparam int unsigned CTRL_FRAME_HZ = 8_000;
  localparam int unsigned HP_MAX_HZ = 16_000;
  localparam int unsigned RBW_MAX_HZ = 8_000;
  localparam int unsigned LP_MAX_HZ = 4_000;
  // Half bit period of the generated clock: a longest time, rounded down
  localparam int unsigned CTRL_HALF_CYCLES = CLK_HZ / (2 * SYS_CLK_HZ);
  localparam int unsigned CTRL_BITS_PER_FRAME = SYS_CLK_HZ / CTRL_FRAME_HZ;
  // Least spacing between two samples: a least time, rounded up
  localparam int unsigned RATE_HP_CYCLES = (CLK_HZ + HP_MAX_HZ - 1) / HP_MAX_HZ;
  localparam int unsigned RATE_RBW_CYCLES = (CLK_HZ + RBW_MAX_HZ - 1) / RBW_MAX_HZ;
  localparam int unsigned RATE_LP_CYCLES = (CLK_HZ + LP_MAX_HZ - 1) / LP_MAX_HZ;
  // Register offsets
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h25;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h27;
  localparam logic [7:0] ADDR_BUF_CFG0 = 8'h32;
  localparam logic [7:0] ADDR_SERIAL_PORT_CONFIG_TWO = 8'h34;
  localparam logic [7:0] ADDR_PDM_SLOT = 8'h36;
  localparam logic [7:0] ADDR_DENSITY_POLARITY_INVERT = 8'h37;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  // Field positions
  localparam int unsigned DIV_LSB = 4;
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned SYNC_STYLE_BIT = 3;
  localparam int unsigned PIN_SEL_BIT = 7;
  localparam int unsigned SLOTS_LSB = 4;
  localparam int unsigned PWR_LSB = 2;
  localparam int unsigned WIDTH_LSB = 0;
  localparam int unsigned POL_BIT = 7;
  localparam int unsigned PDM_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PDM_SLOT = 8'hFF;
  // Encodings
  localparam logic [1:0] SLOT_NONE = 2'h3;
  localparam logic [1:0] WW_16 = 2'h0;
  localparam logic [1:0] WW_24 = 2'h1;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [1:0] {AASP_HP, AASP_RBW, AASP_LP} aasp_pwr_t;
  typedef enum logic {AASP_IDLE, AASP_SHIFT} aasp_frame_t;
endpackage
`default_nettype wire

/* File: aasp_ctrl_model.sv */
/*
  Audio controller model for the far side of the serial port: it makes the
  bit clock and the frame sync, TDM pulse style or I2S square wave.
  Assumes mclk from the bench; both outputs change on falling mclk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module aasp_ctrl_model #(
  parameter int HALF = 6,
  parameter int BITS = 64
) (
  input wire logic mclk,
  input wire logic en,
  input wire logic i2s,
  output logic bclk,
  output logic fs
);
  int ph = 0;
  int bn = 0;
  // Clock stands low while disabled; sync only moves on a bit clock fall
  always @(negedge mclk) begin
    if (!en) begin
      bclk <= 1'b0;
      fs <= 1'b0;
      ph <= 0;
      bn <= 0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      bclk <= !bclk;
      if (bclk) begin
        bn <= (bn + 1) % BITS;
        fs <= i2s ? ((bn + 1) % BITS >= BITS / 2) : ((bn + 1) % BITS == 0);
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule
`default_nettype wire

/* File: test_aasp_serial_port.sv */
/*
  Self-checking bench for the audio serial port: registers, TDM and I2S
  frames, PDM density and slots, FIFO fill and drain.
  Assumes aasp_ctrl_model drives the bit clock and frame sync pins.
*/
`timescale 1ns/1ns
`default_nettype none
module test_aasp_serial_port import aasp_pkg::*;;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sv = 1'b0;
  logic srdy, en = 1'b0, i2s = 1'b0;
  logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000, st = 16'h0000;
  logic bclk, fs, so0, so0_oe, so1, so1_oe, tick, fso_oe;
  logic bco, bco_oe, fso;
  logic [31:0] lfsr = 32'h81313CE1;
  logic [129:0] expq [$];
  logic [129:0] mev;
  logic [63:0] sh0, sh1;
  logic pfs = 1'b0;
  int nb = -1;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int ticks = 0;

  initial forever #5 mclk = !mclk;

  aasp_serial_port #(.HP_GAP(4), .RBW_GAP(8), .LP_GAP(16)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .reg_wr_en(wr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .bclk_in(bclk), .frame_sync_in(fs),
    .sample_valid(sv), .sample_ready(srdy), .sample_x(sx), .sample_y(sy),
    .sample_z(sz), .sample_temp(st), .bit_clock_out(bco), .bit_clock_oe(bco_oe),
    .frame_sync_out(fso), .frame_sync_oe(fso_oe), .serial_out_zero(so0),
    .serial_out_zero_oe(so0_oe), .serial_out_one(so1),
    .serial_out_one_oe(so1_oe), .system_clock_tick(tick)
  );

  aasp_ctrl_model #(.HALF(6), .BITS(64)) i_ctrl (
    .mclk(mclk), .en(en), .i2s(i2s), .bclk(bclk), .fs(fs)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'hA3000000) : (v >> 1);
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(negedge mclk);
    wr <= 1'b0;
  endtask

  // Read data lags the address by one edge, so wait two to be safe
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr <= a;
    repeat (2) @(negedge mclk);
    d = rdata;
  endtask

  // Offer one sample set and hold it until the FIFO takes it
  task automatic push(input logic [15:0] x);
    @(negedge mclk);
    lfsr = nxt(lfsr);
    sx = (x !== 16'h0000) ? x : lfsr[15:0];
    sy = lfsr[31:16];
    lfsr = nxt(lfsr);
    sz = lfsr[15:0];
    st = lfsr[31:16];
    sv <= 1'b1;
    while (srdy !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    sv <= 1'b0;
  endtask

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 80000) begin
      err_total++;
      final_report();
    end
  end

  // Receiver side: sample both lines at each rise, 64 bits after a start
  always @(posedge bclk) begin
    if (nb >= 0 && nb < 64) begin
      sh0 = {sh0[62:0], so0};
      sh1 = {sh1[62:0], so1};
      nb++;
      if (nb == 64 && expq.size() > 0) begin
        mev = expq.pop_front();
        if (mev[129]) chk(sh0, mev[127:64]);
        if (mev[128]) chk(sh1, mev[63:0]);
      end
    end
    if (i2s ? (!fs && pfs) : fs) nb = 0;
    pfs = fs;
  end

  logic [7:0] ra [7] = '{8'h25, 8'h27, 8'h32, 8'h34, 8'h36, 8'h37, 8'h40};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
  // Sync style, enables, port config: TDM4, TDM2/32, TDM2/24 REDUCED_BANDWIDTH_MODE, TDM3 pin 1 LP, I2S
  logic [23:0] cfg [5] = '{24'h080F30, 24'h080F92, 24'h080F95, 24'h080BA8, 24'h000F02};

  initial begin
    logic [7:0] d;
    logic [129:0] ev;
    int n;
    time t0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    reset_n <= 1'b1;
    // Reset values; the unmapped write must leave no trace
    wreg(8'h40, 8'hA5);
    foreach (ra[i]) begin
      rreg(ra[i], d);
      chk(d, rv[i]);
    end
    wreg(8'h25, 8'h30);
    en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      i2s <= (k == 4);
      wreg(8'h32, cfg[k][23:16]);
      wreg(8'h27, cfg[k][15:8]);
      wreg(8'h34, cfg[k][7:0]);
      push(16'h0000);
      repeat (128) @(posedge bclk);
      case (k)
        0: ev = {2'b10, sx, sy, sz, st, 64'h0};
        2: ev = {2'b11, sx, 8'h0, sy, 8'h0, 16'h0, sz, 8'h0, st, 8'h0, 16'h0};
        3: ev = {2'b01, 64'h0, sx, sy, st, 16'h0};
        default: ev = {2'b11, sx, 16'h0, sy, 16'h0, sz, 16'h0, st, 16'h0};
      endcase
      expq.push_back(ev);
      n = 0;
      while (expq.size() > 0 && n < 200) begin
        @(posedge bclk);
        n++;
      end
      chk(expq.size(), 0);
      if (k == 3) chk({so0_oe, so1_oe}, 2'b01);
      if (k == 0) begin
        ticks = 0;
        repeat (64) @(posedge bclk);
        chk(ticks >= 15 && ticks <= 17, 1);
      end
    end
    // Density of x = +half scale on the rising slot, plain then inverted
    for (int p = 0; p < 2; p++) begin
      wreg(8'h37, p ? 8'h81 : 8'h01);
      wreg(8'h36, 8'h31);
      push(16'h4000);
      repeat (8) @(posedge bclk);
      n = 0;
      repeat (64) begin
        @(posedge bclk);
        repeat (4) @(posedge mclk);
        #1;
        n += so0;
      end
      chk(n >= 46 - 32 * p && n <= 50 - 32 * p, 1);
      chk({so0_oe, fso_oe}, 2'b11);
      @(negedge bclk);
      repeat (4) @(posedge mclk);
      #1;
      chk({so0_oe, fso_oe, so1_oe}, 3'b100);
    end
    // Out0 rising slot and sync falling slot left without a channel
    wreg(8'h36, 8'h3C);
    @(posedge bclk);
    repeat (4) @(posedge mclk);
    #1;
    chk({so0_oe, fso_oe}, 2'b01);
    rreg(8'h36, d);
    chk(d, 8'h3C);
    // Far side stalls: fill the FIFO until it refuses, then drain it
    @(negedge mclk);
    en <= 1'b0;
    repeat (4) @(negedge mclk);
    sv <= 1'b1;
    n = 0;
    repeat (12) begin
      n += srdy;
      @(negedge mclk);
    end
    sv <= 1'b0;
    chk(n, 8);
    rreg(8'h38, d);
    chk(d[2], 1'b1);
    en <= 1'b1;
    repeat (16) @(posedge bclk);
    rreg(8'h38, d);
    chk({d[2], srdy}, 2'b01);
    // Controller mode: the port makes its own clock and a one bit TDM pulse
    @(negedge mclk);
    en <= 1'b0;
    wreg(8'h37, 8'h00);
    wreg(8'h32, 8'h08);
    wreg(8'h25, 8'h31);
    chk({bco_oe, fso_oe}, 2'b11);
    // One generated bit is two half periods of 10 ns core cycles
    @(posedge bco);
    t0 = $time;
    @(posedge bco);
    chk($time - t0, 20 * CTRL_HALF_CYCLES);
    @(posedge fso);
    t0 = $time;
    @(negedge fso);
    chk($time - t0, 20 * CTRL_HALF_CYCLES);
    @(posedge fso);
    chk($time - t0, 20 * CTRL_HALF_CYCLES * CTRL_BITS_PER_FRAME);
    final_report();
  end
endmodule
`default_nettype wire
